// file: design/controller_clock_reset_consts.svh
`ifndef CONTROLLER_CLOCK_RESET_CONSTS_SVH
`define CONTROLLER_CLOCK_RESET_CONSTS_SVH

// register byte addresses on the core's memory-mapped bus
`define CCR_CLK_CTRL_ADDR   16'h7f27
`define CCR_RST_DLY_ADDR    16'h7f2f
`define CCR_HOST_RST_ADDR   16'h7f30
`define CCR_PFI_ADDR        16'h7f31

// reset values
`define CCR_CLK_CTRL_RST    8'h10
`define CCR_RST_DLY_RST     8'h00
`define CCR_HOST_RST_RST    8'h01
`define CCR_PFI_RST         8'h00

// core_clock_control fields
`define CCR_RUN_BIT         0
`define CCR_PDN_BIT         1
`define CCR_ROSC_BIT        4
`define CCR_SEL_BIT         5
`define CCR_FREQ_LSB        6
// reset_release_delay field
`define CCR_STP_LSB         0
`define CCR_STP_W           4
// host reset control fields
`define CCR_HRST_BIT        0
`define CCR_STPCLK_BIT      1
// power-fail irq register field
`define CCR_PGI_BIT         0

// timing, figures in their own unit; clock in kHz
`define CCR_CLK_KHZ         100000
`define CCR_POR_MS          20
`define CCR_PLL_LOCK_US     100
`define CCR_ROSC_START_NS   6000
`define CCR_FS_DELAY_NS     2760
`define CCR_GUARD_NS        2000
`define CCR_HANDOVER_CLKS   4
`define CCR_MC_CLKS         4

// derived cycle counts: least times round up, longest round down
`define CCR_POR_CYC   (`CCR_POR_MS * `CCR_CLK_KHZ)
`define CCR_PLL_CYC   ((`CCR_PLL_LOCK_US * `CCR_CLK_KHZ) / 1000)
`define CCR_ROSC_CYC  ((`CCR_ROSC_START_NS * (`CCR_CLK_KHZ / 1000)) / 1000)
`define CCR_FS_CYC    ((`CCR_FS_DELAY_NS * (`CCR_CLK_KHZ / 1000)) / 1000)
`define CCR_GUARD_CYC \
    ((`CCR_GUARD_NS * (`CCR_CLK_KHZ / 1000) + 999) / 1000)

`endif

// file: design/controller_clock_reset_pkg.sv
package controller_clock_reset_pkg;

    typedef enum logic [4:0] {
        FS_IDLE  = 5'b00001,
        FS_WAIT  = 5'b00010,
        FS_HAND  = 5'b00100,
        FS_GUARD = 5'b01000,
        FS_DONE  = 5'b10000
    } failsafe_state_t;

    typedef struct packed {
        logic pll;
        logic ring;
    } clk_src_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        we;
        logic        re;
    } core_bus_req_t;

endpackage

// file: design/controller_clock_reset.sv
// Behaviour
// - standby power-up starts ring, core runs from 00
// - standby reset held 20ms after standby good
// - clearing reset bit sets stop-clock, starts counting
// - 4-bit count sets machine cycles to pin release
// - idle exits only on an interrupt
// - bit0 stops or runs the PLL clock
// - bit1 powers down PLL and clocks
// - PLL stable within 100us after powerup
// - ring-on bit reads live state, writable
// - sleep clears ring-on, wake sets it
// - ring starts within 6us of enable
// - select bit picks PLL or ring, wake clears
// - bits 7:6 choose 12/16/24/32MHz
// - main power-good fall is power fail, starts ring
// - handover starts within 2.76us, two plus two clocks
// - 2us guard, on ring within 6us total
// - power fail raises interrupt to core
// - sleeping or on ring: only flag interrupt
// - on PLL hold internal good; stopped: flash to core
// - flag sits at bit zero of irq register
// - power fail is one of eleven sources
`timescale 1ns/1ns
`include "controller_clock_reset_consts.svh"

module controller_clock_reset #(
    parameter int unsigned POR_CYCLES      = `CCR_POR_CYC,
    parameter int unsigned PLL_LOCK_CYCLES = `CCR_PLL_CYC,
    parameter int unsigned MC_CLKS         = `CCR_MC_CLKS
) (
    // clock and reset
    input  wire logic                                ref_clk_i,
    input  wire logic                                reset_i,
    // core memory-mapped register bus
    input  wire controller_clock_reset_pkg::core_bus_req_t bus_i,
    output logic [7:0]                               bus_rdata_o,
    // power-good pins
    input  wire logic                                standby_power_good_i,
    input  wire logic                                main_power_good_i,
    // core state
    input  wire logic                                core_idle_req_i,
    input  wire logic                                core_sleep_req_i,
    input  wire logic                                core_irq_i,
    input  wire logic                                core_wake_i,
    // resets
    output logic                                     standby_power_on_reset_o,
    output logic                                     core_reset_o,
    output logic [15:0]                              core_start_addr_o,
    output logic                                     host_reset_pin_n_o,
    output logic                                     core_stop_clock_o,
    // clocking
    output controller_clock_reset_pkg::clk_src_t     clk_src_o,
    output logic                                     ring_osc_run_o,
    output logic                                     pll_powerdown_o,
    output logic                                     pll_clock_run_o,
    output logic [1:0]                               core_freq_select_o,
    // power fail, idle and sleep
    output logic                                     internal_power_good_o,
    output logic                                     flash_to_core_o,
    output logic                                     power_fail_irq_o,
    output logic                                     core_idle_o,
    output logic                                     core_sleep_o
);
    import controller_clock_reset_pkg::*;

    localparam logic [7:0] CTL_RST = `CCR_CLK_CTRL_RST;
    localparam logic [7:0] DLY_RST = `CCR_RST_DLY_RST;
    localparam logic [7:0] HRS_RST = `CCR_HOST_RST_RST;
    localparam logic [7:0] PFI_RST = `CCR_PFI_RST;

    function automatic logic cnt_done(input logic [31:0] cnt,
                                      input int unsigned lim);
        cnt_done = (cnt + 32'h1 >= lim);
    endfunction

    // pin synchronisers: three stages, change when stages two and three agree
    logic [2:0] sb_sync_q;
    logic [2:0] mp_sync_q;
    logic       sb_good_q;
    logic       mp_good_q;
    logic       mp_good_dly_q;
    logic       power_fail;

    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
        begin
            sb_sync_q     <= 3'h0;
            mp_sync_q     <= 3'h0;
            sb_good_q     <= 1'b0;
            mp_good_q     <= 1'b0;
            mp_good_dly_q <= 1'b0;
        end
        else
        begin
            sb_sync_q <= {sb_sync_q[1:0], standby_power_good_i};
            mp_sync_q <= {mp_sync_q[1:0], main_power_good_i};
            if (sb_sync_q[1] == sb_sync_q[2])
                sb_good_q <= sb_sync_q[2];
            if (mp_sync_q[1] == mp_sync_q[2])
                mp_good_q <= mp_sync_q[2];
            mp_good_dly_q <= mp_good_q;
        end
    end

    assign power_fail = mp_good_dly_q & ~mp_good_q;

    // register file
    logic [1:0] freq_q;
    logic       sel_q;
    logic       rosc_on_q;
    logic       pdn_q;
    logic       run_q;
    logic [3:0] stop_delay_count_q;
    logic       hrst_q;
    logic       stpclk_q;
    logic       pgi_q;
    logic       idle_q;
    logic       sleep_q;
    logic       wr_clk;
    logic       wr_hrst;
    failsafe_state_t fs_q;
    logic [31:0]     fs_cnt_q;
    logic            core_stopped;

    assign wr_clk  = bus_i.we && bus_i.addr == `CCR_CLK_CTRL_ADDR;
    assign wr_hrst = bus_i.we && bus_i.addr == `CCR_HOST_RST_ADDR;
    assign core_stopped = idle_q | stpclk_q;

    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
        begin
            {freq_q, sel_q, rosc_on_q} <= CTL_RST[7:4];
            {pdn_q, run_q}             <= CTL_RST[1:0];
        end
        else
        begin
            if (wr_clk)
            begin
                freq_q    <= bus_i.wdata[`CCR_FREQ_LSB +: 2];
                sel_q     <= bus_i.wdata[`CCR_SEL_BIT];
                rosc_on_q <= bus_i.wdata[`CCR_ROSC_BIT];
                pdn_q     <= bus_i.wdata[`CCR_PDN_BIT];
                run_q     <= bus_i.wdata[`CCR_RUN_BIT];
            end
            // hardware events override a same-cycle write
            if (core_sleep_req_i && !sleep_q)
                rosc_on_q <= 1'b0;
            if (sleep_q && core_wake_i)
            begin
                rosc_on_q <= 1'b1;
                sel_q     <= 1'b0;
            end
            if (power_fail)
                rosc_on_q <= 1'b1;
            if (fs_q == FS_WAIT && cnt_done(fs_cnt_q, `CCR_FS_CYC))
                sel_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
        begin
            stop_delay_count_q <= DLY_RST[3:0];
            hrst_q    <= HRS_RST[0];
        end
        else
        begin
            if (bus_i.we && bus_i.addr == `CCR_RST_DLY_ADDR)
                stop_delay_count_q <= bus_i.wdata[`CCR_STP_LSB +: `CCR_STP_W];
            if (wr_hrst)
                hrst_q <= bus_i.wdata[`CCR_HRST_BIT];
        end
    end

    // power-good interrupt flag: a new event wins over the clear
    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
            pgi_q <= PFI_RST[0];
        else if (power_fail)
            pgi_q <= 1'b1;
        else if (bus_i.we && bus_i.addr == `CCR_PFI_ADDR
                 && bus_i.wdata[`CCR_PGI_BIT])
            pgi_q <= 1'b0;
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
            bus_rdata_o <= 8'h00;
        else if (bus_i.re)
        begin
            case (bus_i.addr)
                `CCR_CLK_CTRL_ADDR:
                    bus_rdata_o <= {freq_q, sel_q, rosc_on_q, 2'h0,
                                    pdn_q, run_q};
                `CCR_RST_DLY_ADDR:
                    bus_rdata_o <= {4'h0, stop_delay_count_q};
                `CCR_HOST_RST_ADDR:
                    bus_rdata_o <= {6'h00, stpclk_q, hrst_q};
                `CCR_PFI_ADDR:
                    bus_rdata_o <= {7'h00, pgi_q};
                default:
                    bus_rdata_o <= 8'h00;
            endcase
        end
    end

    // standby power-on reset stretch
    logic [31:0] por_cnt_q;
    logic        por_q;

    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i || !sb_good_q)
        begin
            por_cnt_q <= 32'h0;
            por_q     <= 1'b1;
        end
        else if (por_q)
        begin
            por_cnt_q <= por_cnt_q + 32'h1;
            if (cnt_done(por_cnt_q, POR_CYCLES))
                por_q <= 1'b0;
        end
    end

    // ring oscillator start-up: reported running after the longest start
    logic [31:0] rosc_cnt_q;
    logic        rosc_run_q;

    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i || !rosc_on_q)
        begin
            rosc_cnt_q <= 32'h0;
            rosc_run_q <= 1'b0;
        end
        else if (!rosc_run_q)
        begin
            rosc_cnt_q <= rosc_cnt_q + 32'h1;
            if (cnt_done(rosc_cnt_q, `CCR_ROSC_CYC))
                rosc_run_q <= 1'b1;
        end
    end

    // PLL lock wait after powerdown is released
    logic [31:0] pll_cnt_q;
    logic        pll_stable_q;

    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i || pdn_q || !mp_good_q)
        begin
            pll_cnt_q    <= 32'h0;
            pll_stable_q <= 1'b0;
        end
        else if (!pll_stable_q)
        begin
            pll_cnt_q <= pll_cnt_q + 32'h1;
            if (cnt_done(pll_cnt_q, PLL_LOCK_CYCLES))
                pll_stable_q <= 1'b1;
        end
    end

    // core start: held until the stretched reset ends and the ring runs
    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i || por_q)
            core_reset_o <= 1'b1;
        else if (rosc_run_q)
            core_reset_o <= 1'b0;
    end

    // idle and sleep; an interrupt beats a same-cycle idle request
    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i || core_reset_o)
        begin
            idle_q  <= 1'b0;
            sleep_q <= 1'b0;
        end
        else
        begin
            if (core_irq_i)
                idle_q <= 1'b0;
            else if (core_idle_req_i)
                idle_q <= 1'b1;
            if (sleep_q && core_wake_i)
                sleep_q <= 1'b0;
            else if (core_sleep_req_i)
                sleep_q <= 1'b1;
        end
    end

    // host reset release counted in machine cycles
    logic [7:0] mc_div_q;
    logic       mc_tick;
    logic [3:0] rel_cnt_q;
    logic       hrst_dly_q;

    assign mc_tick = (mc_div_q == 8'(MC_CLKS - 1));

    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i || mc_tick)
            mc_div_q <= 8'h00;
        else
            mc_div_q <= mc_div_q + 8'h01;
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
        begin
            hrst_dly_q         <= HRS_RST[0];
            stpclk_q           <= 1'b0;
            rel_cnt_q          <= 4'h0;
            host_reset_pin_n_o <= 1'b0;
        end
        else
        begin
            hrst_dly_q <= hrst_q;
            if (hrst_q)
            begin
                host_reset_pin_n_o <= 1'b0;
                stpclk_q           <= 1'b0;
            end
            else if (hrst_dly_q)
            begin
                stpclk_q  <= 1'b1;
                rel_cnt_q <= stop_delay_count_q;
                host_reset_pin_n_o <= 1'b0;
            end
            else if (rel_cnt_q != 4'h0)
            begin
                if (mc_tick)
                    rel_cnt_q <= rel_cnt_q - 4'h1;
            end
            else
                host_reset_pin_n_o <= 1'b1;
        end
    end

    // fail-safe sequence; only a core running on the PLL needs it
    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
        begin
            fs_q            <= FS_IDLE;
            fs_cnt_q        <= 32'h0;
            flash_to_core_o <= 1'b0;
        end
        else
        begin
            fs_cnt_q <= fs_cnt_q + 32'h1;
            case (fs_q)
                FS_IDLE:
                begin
                    fs_cnt_q <= 32'h0;
                    if (power_fail && !sleep_q && sel_q)
                    begin
                        fs_q            <= FS_WAIT;
                        flash_to_core_o <= core_stopped;
                    end
                end
                FS_WAIT:
                    if (cnt_done(fs_cnt_q, `CCR_FS_CYC))
                    begin
                        fs_q     <= FS_HAND;
                        fs_cnt_q <= 32'h0;
                    end
                FS_HAND:
                begin
                    fs_cnt_q <= 32'h0;
                    if (clk_src_o.ring)
                        fs_q <= FS_GUARD;
                end
                FS_GUARD:
                    if (cnt_done(fs_cnt_q, `CCR_GUARD_CYC))
                        fs_q <= FS_DONE;
                FS_DONE:
                begin
                    fs_q            <= FS_IDLE;
                    flash_to_core_o <= 1'b0;
                end
                default:
                    fs_q <= FS_IDLE;
            endcase
        end
    end

    // break-before-make source switch: both off for the handover clocks
    clk_src_t    want_src;
    logic [31:0] hand_cnt_q;

    assign want_src = sel_q ? clk_src_t'(2'b10) : clk_src_t'(2'b01);

    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
        begin
            clk_src_o  <= clk_src_t'(2'b01);
            hand_cnt_q <= 32'h0;
        end
        else if (clk_src_o == want_src)
            hand_cnt_q <= 32'h0;
        else if (clk_src_o != clk_src_t'(2'b00))
            clk_src_o <= clk_src_t'(2'b00);
        else if (cnt_done(hand_cnt_q, `CCR_HANDOVER_CLKS))
            clk_src_o <= want_src;
        else
            hand_cnt_q <= hand_cnt_q + 32'h1;
    end

    // registered outputs
    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
        begin
            standby_power_on_reset_o <= 1'b1;
            core_start_addr_o        <= 16'h0000;
            core_stop_clock_o        <= 1'b0;
            ring_osc_run_o           <= 1'b0;
            pll_powerdown_o          <= 1'b0;
            pll_clock_run_o          <= 1'b0;
            core_freq_select_o       <= 2'h0;
            internal_power_good_o    <= 1'b0;
            power_fail_irq_o         <= 1'b0;
            core_idle_o              <= 1'b0;
            core_sleep_o             <= 1'b0;
        end
        else
        begin
            standby_power_on_reset_o <= por_q;
            core_start_addr_o        <= 16'h0000;
            core_stop_clock_o        <= stpclk_q;
            ring_osc_run_o           <= rosc_run_q;
            pll_powerdown_o          <= pdn_q;
            pll_clock_run_o <= run_q & ~pdn_q & pll_stable_q;
            core_freq_select_o       <= freq_q;
            internal_power_good_o <= mp_good_q && fs_q == FS_IDLE;
            power_fail_irq_o         <= pgi_q;
            core_idle_o              <= idle_q;
            core_sleep_o             <= sleep_q;
        end
    end

endmodule

// file: dv/controller_clock_reset_assertions.sv
`timescale 1ns/1ns
module controller_clock_reset_assertions #(
    parameter int unsigned POR_CYCLES = 50
) (
    // clock, reset, bus
    input wire logic                                   ref_clk_i,
    input wire logic                                   reset_i,
    input wire controller_clock_reset_pkg::core_bus_req_t bus_i,
    // pins and core
    input wire logic        main_power_good_i,
    input wire logic        standby_power_good_i,
    input wire logic        core_irq_i,
    // watched outputs
    input wire logic        standby_power_on_reset_o,
    input wire logic [15:0] core_start_addr_o,
    input wire logic        host_reset_pin_n_o,
    input wire logic        core_stop_clock_o,
    input wire logic        pll_powerdown_o,
    input wire logic        pll_clock_run_o,
    input wire logic [1:0]  core_freq_select_o,
    input wire logic        internal_power_good_o,
    input wire logic        power_fail_irq_o,
    input wire logic        core_idle_o,
    input wire controller_clock_reset_pkg::clk_src_t clk_src_o
);
    import controller_clock_reset_pkg::*;
    // lock bound sized for the short simulation lock count
    localparam int PLL_MAX = 60;
    logic [31:0] sb_cnt_q;
    logic        hrst_q;
    logic        run_q;
    logic        hrst_wr;
    logic        ctl_wr;
    assign hrst_wr = bus_i.we && bus_i.addr == 16'h7f30;
    assign ctl_wr  = bus_i.we && bus_i.addr == 16'h7f27;
    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i || !standby_power_good_i)
            sb_cnt_q <= '0;
        else if (sb_cnt_q < POR_CYCLES)
            sb_cnt_q <= sb_cnt_q + 32'h1;
    end
    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
            hrst_q <= 1'b1;
        else if (hrst_wr)
            hrst_q <= bus_i.wdata[0];
    end
    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
            run_q <= 1'b0;
        else if (ctl_wr)
            run_q <= bus_i.wdata[0];
    end
    default clocking @(posedge ref_clk_i);
    endclocking
    default disable iff (reset_i);
    a_start_at_zero:
    assert property (core_start_addr_o == 16'h0000)
        else $error("start address not zero");
    a_por_stretch:
    assert property (!standby_power_on_reset_o |-> sb_cnt_q >= POR_CYCLES)
        else $error("standby reset released early");
    a_stop_clock_set:
    assert property (hrst_wr && !bus_i.wdata[0] && hrst_q
        |-> ##[1:4] core_stop_clock_o) else $error("stop clock not set");
    a_pin_release_bound:
    assert property (hrst_wr && !bus_i.wdata[0] && hrst_q
        |=> !host_reset_pin_n_o ##[1:80] host_reset_pin_n_o)
        else $error("reset pin release wrong");
    a_powerdown_stops_pll:
    assert property (pll_powerdown_o |=> !pll_clock_run_o)
        else $error("pll clock runs in powerdown");
    a_pll_lock_bound:
    assert property ($fell(pll_powerdown_o) && run_q && main_power_good_i
        |-> ##[1:PLL_MAX] pll_clock_run_o) else $error("pll not stable");
    a_freq_follows_write:
    assert property (ctl_wr |-> ##2
        core_freq_select_o == $past(bus_i.wdata[7:6], 2))
        else $error("frequency select wrong");
    a_no_src_overlap:
    assert property (!(clk_src_o.pll && clk_src_o.ring))
        else $error("two clock sources at once");
    a_handover_gap:
    assert property ($fell(clk_src_o.pll) && !internal_power_good_o
        |-> clk_src_o == 2'b00 [*4]) else $error("handover gap wrong");
    a_ring_switch_time:
    assert property ($fell(main_power_good_i) && clk_src_o.pll
        |-> ##[1:599] clk_src_o == 2'b01) else $error("ring switch late");
    a_fail_irq_raised:
    assert property ($fell(main_power_good_i)
        |-> ##[1:12] power_fail_irq_o) else $error("no power fail irq");
    a_good_held_low:
    assert property (!internal_power_good_o && !clk_src_o.ring
        |=> !internal_power_good_o) else $error("internal good early");
    a_idle_exit_irq:
    assert property ($fell(core_idle_o) |-> $past(core_irq_i, 2))
        else $error("idle left without irq");
endmodule

bind controller_clock_reset controller_clock_reset_assertions #(
    .POR_CYCLES(POR_CYCLES)
) u_check (
    .ref_clk_i, .reset_i, .bus_i, .main_power_good_i,
    .standby_power_good_i, .core_irq_i, .standby_power_on_reset_o,
    .core_start_addr_o, .host_reset_pin_n_o, .core_stop_clock_o,
    .pll_powerdown_o, .pll_clock_run_o, .core_freq_select_o,
    .internal_power_good_o, .power_fail_irq_o, .core_idle_o, .clk_src_o
);

// file: dv/power_supervisor_model.sv
`timescale 1ns/1ns
module power_supervisor_model (
    // bench control
    input  wire logic       ref_clk_i,
    input  wire logic       fail_i,
    input  wire logic [7:0] ramp_i,
    // power-good pins
    output logic            standby_power_good_o,
    output logic            main_power_good_o
);
    logic [15:0] up_q = 16'h0;
    initial standby_power_good_o = 1'b0;
    // rails come up in turn; a fail drops only the main rail
    always @(posedge ref_clk_i)
    begin
        if (fail_i)
            up_q <= #1 16'h0;
        else if (up_q != 16'hffff)
            up_q <= #1 up_q + 16'h1;
    end
    always @(posedge ref_clk_i)
    begin
        if (up_q == {8'h0, ramp_i})
            standby_power_good_o <= #1 1'b1;
    end
    assign main_power_good_o = !fail_i && up_q > {7'h0, ramp_i, 1'b0};
endmodule

// file: dv/controller_clock_reset_tb.sv
`timescale 1ns/1ns
module controller_clock_reset_tb;
    import controller_clock_reset_pkg::*;
    localparam int POR = 50;
    localparam int PLL = 20;
    logic          ref_clk_i = 1'b0;
    logic          reset_i = 1'b1;
    core_bus_req_t bus_i = '0;
    logic          core_idle_req_i = 1'b0, core_sleep_req_i = 1'b0;
    logic          core_irq_i = 1'b0, core_wake_i = 1'b0, fail = 1'b0;
    wire logic     standby_power_good_i, main_power_good_i;
    logic [7:0]    bus_rdata_o;
    logic [15:0]   core_start_addr_o;
    logic [1:0]    core_freq_select_o;
    clk_src_t      clk_src_o;
    logic          standby_power_on_reset_o, core_reset_o, on_ring, re_d;
    logic          host_reset_pin_n_o, core_stop_clock_o, ring_osc_run_o;
    logic          pll_powerdown_o, pll_clock_run_o, internal_power_good_o;
    logic          flash_to_core_o, power_fail_irq_o, core_idle_o;
    logic          core_sleep_o;
    logic [7:0]    exp_q[$];
    int            n_fail = 0, compares = 0;

    always #5 ref_clk_i = ~ref_clk_i;
    always_comb on_ring = (clk_src_o === 2'b01);

    power_supervisor_model PSM (
        .ref_clk_i(ref_clk_i), .fail_i(fail), .ramp_i(8'h14),
        .standby_power_good_o(standby_power_good_i),
        .main_power_good_o(main_power_good_i)
    );
    controller_clock_reset #(.POR_CYCLES(POR), .PLL_LOCK_CYCLES(PLL)) DUT (
        .ref_clk_i, .reset_i, .bus_i, .bus_rdata_o, .standby_power_good_i,
        .main_power_good_i, .core_idle_req_i, .core_sleep_req_i,
        .core_irq_i, .core_wake_i, .standby_power_on_reset_o, .core_reset_o,
        .core_start_addr_o, .host_reset_pin_n_o, .core_stop_clock_o,
        .clk_src_o, .ring_osc_run_o, .pll_powerdown_o, .pll_clock_run_o,
        .core_freq_select_o, .internal_power_good_o, .flash_to_core_o,
        .power_fail_irq_o, .core_idle_o, .core_sleep_o
    );

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask
    task automatic cmp(input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e)
        begin
            n_fail++;
            $display("Error t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        tick(1);
        bus_i.addr = a;
        bus_i.wdata = d;
        bus_i.we = 1'b1;
        tick(1);
        bus_i.we = 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        tick(1);
        exp_q.push_back(e);
        bus_i.addr = a;
        bus_i.re = 1'b1;
        tick(1);
        bus_i.re = 1'b0;
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        tick(1);
        s = 1'b0;
    endtask
    task automatic await(ref logic s, input logic v, output int n);
        n = 0;
        while (s !== v && n < 1000)
        begin
            tick(1);
            n++;
        end
    endtask
    task automatic tdone(input string s);
        $display("test %0s done", s);
    endtask
    task automatic end_of_test();
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // read data lands one cycle after the strobe
    initial re_d = 1'b0;
    always @(posedge ref_clk_i)
    begin
        if (re_d)
            cmp(exp_q.pop_front(), bus_rdata_o);
        re_d <= bus_i.re;
    end

    initial
    begin
        repeat (5000) @(posedge ref_clk_i);
        n_fail++;
        end_of_test();
    end

    initial
    begin
        int n;
        int c;
        void'($urandom(32'h67fefb8a));
        tick(8);
        reset_i = 1'b0;
        rd(16'h7f27, 8'h10);
        rd(16'h7f2f, 8'h00);
        rd(16'h7f30, 8'h01);
        rd(16'h7f31, 8'h00);
        rd(16'h7f28, 8'h00);
        cmp(0, host_reset_pin_n_o);
        cmp(1, core_reset_o);
        tdone("reset values");
        await(standby_power_on_reset_o, 1'b0, n);
        cmp(1, n >= POR && n < POR + 40);
        await(core_reset_o, 1'b0, n);
        cmp(0, core_reset_o);
        cmp(1, ring_osc_run_o);
        tdone("standby reset");
        for (int i = 0; i < 4; i++)
        begin
            wr(16'h7f27, {i[1:0], 6'h11});
            tick(2);
            cmp(i[1:0], core_freq_select_o);
            rd(16'h7f27, {i[1:0], 6'h11});
        end
        tdone("frequency select");
        wr(16'h7f27, 8'h13);
        tick(2);
        cmp(0, pll_clock_run_o);
        wr(16'h7f27, 8'h11);
        tick(PLL + 5);
        cmp(1, pll_clock_run_o);
        wr(16'h7f27, 8'h10);
        tick(2);
        cmp(0, pll_clock_run_o);
        tdone("pll control");
        for (int k = 0; k < 3; k++)
        begin
            c = (k == 0) ? 0 : (k == 1) ? 15 : $urandom_range(14, 1);
            wr(16'h7f2f, 8'hf0 | c[7:0]);
            rd(16'h7f2f, c[7:0]);
            wr(16'h7f30, 8'h01);
            tick(3);
            cmp(0, host_reset_pin_n_o);
            wr(16'h7f30, 8'h00);
            await(host_reset_pin_n_o, 1'b1, n);
            cmp(1, n >= 4 * c - 1 && n <= 4 * c + 6);
            cmp(1, core_stop_clock_o);
            rd(16'h7f30, 8'h02);
        end
        tdone("reset release");
        pulse(core_idle_req_i);
        tick(5);
        cmp(1, core_idle_o);
        pulse(core_irq_i);
        tick(2);
        cmp(0, core_idle_o);
        tdone("idle");
        wr(16'h7f27, 8'h31);
        pulse(core_sleep_req_i);
        tick(2);
        cmp(1, core_sleep_o);
        rd(16'h7f27, 8'h21);
        pulse(core_wake_i);
        tick(2);
        rd(16'h7f27, 8'h11);
        tdone("sleep");
        fail = 1'b1;
        tick(20);
        rd(16'h7f31, 8'h01);
        cmp(1, power_fail_irq_o);
        cmp(2'b01, clk_src_o);
        wr(16'h7f31, 8'h01);
        tick(2);
        rd(16'h7f31, 8'h00);
        fail = 1'b0;
        tick(100);
        tdone("fail on ring");
        wr(16'h7f27, 8'h31);
        tick(20);
        cmp(2'b10, clk_src_o);
        fail = 1'b1;
        await(on_ring, 1'b1, n);
        cmp(1, n <= 300);
        cmp(0, internal_power_good_o);
        cmp(1, flash_to_core_o);
        rd(16'h7f27, 8'h11);
        cmp(1, power_fail_irq_o);
        fail = 1'b0;
        tick(5);
        tdone("fail on pll");
        end_of_test();
    end
endmodule
